// ===== step_fault_core.sv
// Step input conditioning, fault latching and fault indicator for a stepping driver.
module step_fault_core #(
   parameter int unsigned SLOT_CYCLES = fault_pkg::SLOT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic step_strobe,
   input wire logic rotation_sense,
   input wire logic output_permit,
   input wire logic over_current_trip,
   input wire logic over_voltage_trip,
   input wire logic motor_line_fault,
   output logic step_pulse,
   output logic step_dir,
   output logic windings_enable,
   output logic fault_led,
   output logic [2:0] fault_code
);
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_FAULT = 2'b10
   } state_e;

   // Shifts one new pin sample into a two-stage synchroniser chain.
   // Every pin uses it, so that no chain can end up shorter than the others.
   function automatic logic [1:0] shift_in(input logic [1:0] chain, input logic pin);
      shift_in = {chain[0], pin};
   endfunction

   // Every pin arrives from outside this clock domain, so only bit 1 of a chain is read.
   logic [1:0] s_step;
   logic [1:0] s_dir;
   logic [1:0] s_perm;
   logic [1:0] s_oc;
   logic [1:0] s_ov;
   logic [1:0] s_sc;
   logic [1:0] next_s_step;
   logic [1:0] next_s_dir;
   logic [1:0] next_s_perm;
   logic [1:0] next_s_oc;
   logic [1:0] next_s_ov;
   logic [1:0] next_s_sc;

   // Latched faults and the state that they force.
   logic oc;
   logic ov;
   logic sc;
   logic next_oc;
   logic next_ov;
   logic next_sc;
   state_e state;
   state_e next_state;
   logic next_windings;

   // Step edge detector and direction register.
   logic step_prev;
   logic next_step_prev;
   logic next_step_pulse;
   logic next_step_dir;

   // The live priority code, and the code held for the running period.
   logic [2:0] live_code;
   logic [2:0] code;
   logic [2:0] next_code;
   logic [2:0] next_fault_code;
   logic next_fault_led;

   flash_pattern_if fp ();

   // The flasher owns the period timing; this core only tells it how many flashes to show.
   led_flasher #(
      .SLOT_CYCLES(SLOT_CYCLES),
      .SLOTS(fault_pkg::SLOTS_PER_PERIOD)
   ) u_flasher (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .fp(fp)
   );

   // Input synchronisers. A metastable first stage never reaches logic; the price is two
   // cycles of latency on every pin, far inside the controller's setup margins.
   always_comb begin
      next_s_step = shift_in(s_step, step_strobe);
      next_s_dir = shift_in(s_dir, rotation_sense);
      next_s_perm = shift_in(s_perm, output_permit);
      next_s_oc = shift_in(s_oc, over_current_trip);
      next_s_ov = shift_in(s_ov, over_voltage_trip);
      next_s_sc = shift_in(s_sc, motor_line_fault);
   end

   // Reset empties the chains, so the first samples after reset are fresh ones.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_step <= 2'h0;
         s_dir <= 2'h0;
         s_perm <= 2'h0;
         s_oc <= 2'h0;
         s_ov <= 2'h0;
         s_sc <= 2'h0;
      end else begin
         s_step <= next_s_step;
         s_dir <= next_s_dir;
         s_perm <= next_s_perm;
         s_oc <= next_s_oc;
         s_ov <= next_s_ov;
         s_sc <= next_s_sc;
      end
   end

   // Fault latches and the run or fault state. The windings drop one cycle after the
   // state turns, about four cycles after a trip reaches its pin.
   // Nothing but reset, which stands for a power cycle, clears a latch.
   always_comb begin
      next_oc = oc | s_oc[1];
      next_ov = ov | s_ov[1];
      next_sc = sc | s_sc[1];
      next_state = (next_oc | next_ov | next_sc) ? ST_FAULT : ST_RUN;
      case (state)
         ST_RUN: begin
            // An open permit input reads high through the board pull-up.
            next_windings = s_perm[1];
         end
         ST_FAULT: begin
            next_windings = 1'b0;
         end
         default: begin
            // Unreachable codes drop the windings, which is the safe side.
            next_windings = 1'b0;
         end
      endcase
   end

   // Latches and the winding drive register here; only reset clears the latches.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         oc <= 1'b0;
         ov <= 1'b0;
         sc <= 1'b0;
         state <= ST_RUN;
         windings_enable <= 1'b0;
      end else begin
         oc <= next_oc;
         ov <= next_ov;
         sc <= next_sc;
         state <= next_state;
         windings_enable <= next_windings;
      end
   end

   // Step edge detection. The detector resets low, the idle level of the strobe, so that
   // no false step follows reset. Steps are taken only while permitted and healthy.
   // A rising pin edge shows as a one-cycle pulse three cycles later.
   always_comb begin
      next_step_prev = s_step[1];
      next_step_pulse = s_step[1] & ~step_prev & s_perm[1] & (state == ST_RUN);
      next_step_dir = s_dir[1];
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         step_prev <= 1'b0;
         step_pulse <= 1'b0;
         step_dir <= 1'b0;
      end else begin
         step_prev <= next_step_prev;
         step_pulse <= next_step_pulse;
         step_dir <= next_step_dir;
      end
   end

   // Priority picks the single fault to show.
   always_comb begin
      if (oc) begin
         live_code = fault_pkg::FLASH_OVER_CURRENT;
      end else if (ov) begin
         live_code = fault_pkg::FLASH_OVER_VOLTAGE;
      end else if (sc) begin
         live_code = fault_pkg::FLASH_SHORT;
      end else begin
         live_code = fault_pkg::FLASH_NONE;
      end
      // The flashed code only changes at a period boundary so a pattern is never cut short; fault_code follows the live code.
      // The price is that a new fault may wait up to one whole period before it is flashed.
      next_code = code;
      if (fp.period_tick) begin
         next_code = live_code;
      end
      next_fault_code = live_code;
      next_fault_led = fp.indicator_on;
   end

   // The indicator copy adds one cycle of delay so that the pin comes from a flip-flop.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         code <= fault_pkg::FLASH_NONE;
         fault_led <= 1'b0;
         fault_code <= fault_pkg::FLASH_NONE;
      end else begin
         code <= next_code;
         fault_led <= next_fault_led;
         fault_code <= next_fault_code;
      end
   end

   // The flasher reads the held code, never the live one.
   assign fp.flash_count = code;
endmodule // step_fault_core

// ===== flash_pattern_if.sv
// Interface carrying the flash request and indicator state between the fault core and the flasher.
interface flash_pattern_if;
   logic [2:0] flash_count;
   logic period_tick;
   logic indicator_on;

   modport core (
      output flash_count,
      input period_tick,
      input indicator_on
   );

   modport flasher (
      input flash_count,
      output period_tick,
      output indicator_on
   );
endinterface

// ===== fault_pkg.sv
// Constants for the step sequencing and fault indication logic.
package fault_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   localparam real PERIOD_S = 3.0;
   localparam int unsigned PERIOD_CYCLES = 375000000;
   localparam real SLOT_MS = 250.0;
   localparam int unsigned SLOT_CYCLES = 31250000;
   localparam int unsigned SLOTS_PER_PERIOD = 12;
   localparam logic [2:0] FLASH_NONE = 3'h0;
   localparam logic [2:0] FLASH_OVER_CURRENT = 3'h1;
   localparam logic [2:0] FLASH_OVER_VOLTAGE = 3'h2;
   localparam logic [2:0] FLASH_SHORT = 3'h4;
   localparam real SETUP_US = 5.0;
   localparam int unsigned SETUP_CYCLES = 625;
endpackage

// ===== led_flasher.sv
// Flasher that lights the indicator a given number of times in each period.
module led_flasher #(
   parameter int unsigned SLOT_CYCLES = fault_pkg::SLOT_CYCLES,
   parameter int unsigned SLOTS = fault_pkg::SLOTS_PER_PERIOD
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   flash_pattern_if.flasher fp
);
   logic [31:0] cyc;
   logic [31:0] next_cyc;
   logic [4:0] slot;
   logic [4:0] next_slot;
   logic lit;
   logic next_lit;
   logic tick;
   logic next_tick;

   always_comb begin
      next_cyc = cyc + 32'h1;
      next_slot = slot;
      next_tick = 1'b0;
      if (cyc >= SLOT_CYCLES - 1) begin
         next_cyc = 32'h0;
         if (slot >= 5'(SLOTS - 1)) begin
            next_slot = 5'h0;
            next_tick = 1'b1;
         end else begin
            next_slot = slot + 5'h1;
         end
      end
      // Even slots carry the flashes; an all-dark period means no fault.
      next_lit = (next_slot[0] == 1'b0) && (next_slot[4:1] < {1'b0, fp.flash_count});
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cyc <= 32'h0;
         slot <= 5'h0;
         lit <= 1'b0;
         tick <= 1'b0;
      end else begin
         cyc <= next_cyc;
         slot <= next_slot;
         lit <= next_lit;
         tick <= next_tick;
      end
   end

   assign fp.indicator_on = lit;
   assign fp.period_tick = tick;
endmodule // led_flasher

// ===== step_fault_core_assertions.sv
// Assertions on the ports of the step and fault indicator core.
module sfc_chk #(parameter int unsigned SC = 4) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic step_strobe,
   input wire logic rotation_sense,
   input wire logic output_permit,
   input wire logic over_current_trip,
   input wire logic over_voltage_trip,
   input wire logic motor_line_fault,
   input wire logic step_pulse,
   input wire logic step_dir,
   input wire logic windings_enable,
   input wire logic fault_led,
   input wire logic [2:0] fault_code
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIM = 8;
   // Counts how long the indicator has been lit without a break.
   int lit_run;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lit_run <= 0;
      end else if (fault_led) begin
         lit_run <= lit_run + 1;
      end else begin
         lit_run <= 0;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_step;
      $rose(step_strobe) && output_permit && windings_enable;
   endsequence
   sequence s_trip;
      over_current_trip || over_voltage_trip || motor_line_fault;
   endsequence
   a_step_taken: assert property (s_step |-> ##[3:5] step_pulse)
      else $error("step lost");
   a_inhibit_step: assert property ((!output_permit)[*8] |-> !step_pulse)
      else $error("step while inhibited");
   a_fault_frees: assert property (s_trip |-> ##[1:6] !windings_enable)
      else $error("windings still driven");
   a_fault_held: assert property (fault_code != 3'h0 |=> fault_code != 3'h0 && !windings_enable)
      else $error("fault cleared");
   a_oc_first: assert property (over_current_trip |-> ##[1:LIM] fault_code == 3'h1)
      else $error("over current not shown");
   a_short_shown: assert property (motor_line_fault |-> ##[1:LIM] fault_code != 3'h0)
      else $error("line fault not shown");
   a_dark_idle: assert property (fault_code == 3'h0 |-> !fault_led)
      else $error("lit with no fault");
   a_dir_tracks: assert property ($stable(rotation_sense)[*5] |-> step_dir == rotation_sense)
      else $error("direction lost");
   a_flash_width: assert property (lit_run <= SC)
      else $error("flash longer than one slot");
endmodule // sfc_chk
bind step_fault_core sfc_chk #(.SC(SLOT_CYCLES)) chk_u (.*);

// ===== step_ctrl_model.sv
// Behavioural motion controller driving the step, sense and permit pins.
module step_ctrl_model (
   input wire logic sys_clk,
   output logic step_strobe,
   output logic rotation_sense,
   output logic output_permit
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      step_strobe = 1'h0;
      rotation_sense = 1'h0;
      output_permit = 1'h1;
   end
   // Widths are 313 cycles because 312 would fall just short of 2.5 us.
   task automatic step(input logic dir, input logic permit);
      output_permit <= permit;
      repeat (fault_pkg::SETUP_CYCLES + 1) @(posedge sys_clk);
      rotation_sense <= dir;
      repeat (fault_pkg::SETUP_CYCLES + 1) @(posedge sys_clk);
      step_strobe <= 1'h1;
      repeat (313) @(posedge sys_clk);
      step_strobe <= 1'h0;
      repeat (313) @(posedge sys_clk);
   endtask
endmodule // step_ctrl_model

// ===== step_dir_fault_indicator_tb.sv
// Self-checking bench for the step and fault indicator core.
module step_dir_fault_indicator_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst_n, step_strobe, rotation_sense, output_permit, oc, ov, ml;
   logic step_pulse, step_dir, windings_enable, fault_led;
   logic [2:0] fault_code;
   int failures = 0, n_tests = 0, pulses = 0, cyc = 0;
   step_ctrl_model ctrl_u (.sys_clk, .step_strobe, .rotation_sense, .output_permit);
   step_fault_core #(.SLOT_CYCLES(4)) dut_u (.sys_clk, .rst_n, .step_strobe, .rotation_sense,
      .output_permit, .over_current_trip(oc), .over_voltage_trip(ov), .motor_line_fault(ml),
      .step_pulse, .step_dir, .windings_enable, .fault_led, .fault_code);
   initial begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      pulses <= pulses + int'(step_pulse === 1'h1);
      if (cyc == 20000) begin
         failures = failures + 1;
         end_sim();
      end
   end
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons=%0d mismatches=%0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Two periods settle the pattern; any 48-cycle window then holds one whole period.
   task automatic flashes(input logic [2:0] code);
      int n;
      logic prev;
      n = 0;
      repeat (96) @(posedge sys_clk);
      prev = fault_led;
      repeat (48) begin
         @(posedge sys_clk);
         n += int'(fault_led && !prev);
         prev = fault_led;
      end
      chk(fault_code, code);
      chk(3'(n), code);
   endtask
   task automatic trip(input int which);
      {oc, ov, ml} <= 3'(which);
      repeat (8) @(posedge sys_clk);
      {oc, ov, ml} <= 3'h0;
   endtask
   task automatic t_step();
      int p0 = pulses;
      ctrl_u.step(1'h1, 1'h1);
      chk(3'(pulses - p0), 3'h1);
      chk({2'h0, step_dir}, 3'h1);
      ctrl_u.step(1'h0, 1'h0);
      chk(3'(pulses - p0), 3'h1);
      ctrl_u.step(1'h0, 1'h1);
      chk({2'h0, step_dir}, 3'h0);
      chk(3'(pulses - p0), 3'h2);
      $display("t_step done");
   endtask
   task automatic t_fault();
      int p0;
      flashes(3'h0);
      trip(3);
      flashes(3'h2);
      chk({2'h0, windings_enable}, 3'h0);
      trip(4);
      flashes(3'h1);
      p0 = pulses;
      ctrl_u.step(1'h1, 1'h1);
      chk(3'(pulses - p0), 3'h0);
      $display("t_fault done");
   endtask
   task automatic t_short();
      rst_n <= 1'h0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'h1;
      repeat (4) @(posedge sys_clk);
      chk({2'h0, windings_enable}, 3'h1);
      trip(1);
      flashes(3'h4);
      $display("t_short done");
   endtask
   initial begin
      {rst_n, oc, ov, ml} = 4'h0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'h1;
      repeat (2) @(posedge sys_clk);
      t_step();
      t_fault();
      t_short();
      end_sim();
   end
endmodule // step_dir_fault_indicator_tb
